/* src/nvsac_host.sv */
// Purpose: Host controller that drives a nonvolatile SRAM over its pins.
// Assumes: One command at a time; the device keeps its own rules.
// Notes:   Pins are sampled through two flip-flops before use.
// Notes on behaviour
// - Address stable through write; data at end
// - Host keeps output enable high while writing
// - Without capacitor host disables automatic save; host sends it only when given CMD_AUTO_OFF
// - No write pending: blocked, busy undriven
// - Six reads disable automatic save
`timescale 1ns/1ns
module nvsac_host #(
  parameter int unsigned WORD_MODE       = 1,
  parameter int unsigned STORE_DELAY_CYC = nvsac_pkg::STORE_REQ_DELAY_CYC,
  parameter int unsigned STORE_TIME_CYC  = nvsac_pkg::STORE_TIME_CYC
) (
  // Clock and reset.
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_ARST_N,
  // Command port.
  input  wire logic        I_CMD_VALID,
  input  wire logic [2:0]  I_CMD,
  input  wire logic [16:0] I_CMD_ADDR,
  input  wire logic [15:0] I_CMD_WDATA,
  input  wire logic [1:0]  I_CMD_LANES,
  output logic             O_CMD_READY,
  output logic             O_RSP_VALID,
  output logic [15:0]      O_RSP_RDATA,
  output logic             O_NO_CAP_SEEN,
  // Device pins.
  output logic [16:0]      O_ADDR,
  output logic             O_CHIP_SELECT_N,
  output logic             O_OUTPUT_ENABLE_N,
  output logic             O_WRITE_ENABLE_N,
  output logic             O_UPPER_BYTE_EN_N,
  output logic             O_LOWER_BYTE_EN_N,
  input  wire logic [15:0] I_DQ,
  output logic [15:0]      O_DQ,
  output logic             O_DQ_OE,
  input  wire logic        I_STORE_BUSY_N,
  output logic             O_STORE_BUSY_N,
  output logic             O_STORE_BUSY_OE
);
  if (WORD_MODE > 1) begin : g_bad_mode
    $error("WORD_MODE must be 0 or 1");
  end
  if (STORE_DELAY_CYC < 1 || STORE_TIME_CYC < 2) begin : g_bad_delay
    $error("delay counts too small");
  end

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_READ  = 7'h02,
    ST_WRITE = 7'h04,
    ST_RECOV = 7'h08,
    ST_HWREQ = 7'h10,
    ST_BUSY  = 7'h20,
    ST_WAITH = 7'h40
  } nvsac_state_e;

  localparam int unsigned CW = 32;
  logic                 busy_n_s;
  logic [15:0]          dq_s;
  nvsac_state_e         st_q, st_d;
  logic [CW-1:0]        cnt_q, cnt_d;
  logic [2:0]           seq_q, seq_d;
  logic [2:0]           cmd_q, cmd_d;
  logic [16:0]          addr_q, addr_d;
  logic [15:0]          wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0]           lanes_q, lanes_d;
  logic                 cs_q, cs_d, oe_q, oe_d, we_q, we_d, dqoe_q, dqoe_d;
  logic                 rsp_q, rsp_d, rdy_q, rdy_d, hsb_q, hsb_d, nocap_q, nocap_d;

  nvsac_sync #(.RESET_VAL(1'b1)) u_busy_sync (
    .i_clk   (I_SYS_CLK),
    .i_arst_n(I_ARST_N),
    .i_d     (I_STORE_BUSY_N),
    .o_q     (busy_n_s)
  );

  for (genvar g = 0; g < 16; g++) begin : g_dq_sync
    nvsac_sync #(.RESET_VAL(1'b0)) u_dq_sync (
      .i_clk   (I_SYS_CLK),
      .i_arst_n(I_ARST_N),
      .i_d     (I_DQ[g]),
      .o_q     (dq_s[g])
    );
  end

  function automatic logic [15:0] seq_addr(input logic [2:0] i, input logic [2:0] c);
    logic [15:0] a;
    a = nvsac_pkg::SEQ_ADDR_0;
    case (i)
      3'h1: a = nvsac_pkg::SEQ_ADDR_1;
      3'h2: a = nvsac_pkg::SEQ_ADDR_2;
      3'h3: a = nvsac_pkg::SEQ_ADDR_3;
      3'h4: a = nvsac_pkg::SEQ_ADDR_4;
      3'h5: begin
        case (c)
          nvsac_pkg::CMD_AUTO_OFF: a = nvsac_pkg::SEQ_AUTO_OFF;
          nvsac_pkg::CMD_AUTO_ON:  a = nvsac_pkg::SEQ_AUTO_ON;
          nvsac_pkg::CMD_RESTORE:  a = nvsac_pkg::SEQ_RESTORE;
          default:                 a = nvsac_pkg::SEQ_SAVE;
        endcase
      end
      default: a = nvsac_pkg::SEQ_ADDR_0;
    endcase
    return a;
  endfunction : seq_addr

  always_comb begin
    st_d = st_q;     cnt_d = cnt_q;     seq_d = seq_q;     cmd_d = cmd_q;
    addr_d = addr_q; wdata_d = wdata_q; rdata_d = rdata_q; lanes_d = lanes_q;
    cs_d = cs_q;     oe_d = oe_q;       we_d = we_q;       dqoe_d = dqoe_q;
    rsp_d = 1'b0;    rdy_d = 1'b0;      hsb_d = 1'b0;      nocap_d = nocap_q;
    case (st_q)
      ST_IDLE: begin
        // Access waits while busy is low from any source.
        if (busy_n_s) begin
          rdy_d = 1'b1;
        end
        if (rdy_q && I_CMD_VALID) begin
          rdy_d   = 1'b0;
          cmd_d   = I_CMD;
          addr_d  = (WORD_MODE == 1) ? {1'b0, I_CMD_ADDR[15:0]} : I_CMD_ADDR;
          wdata_d = I_CMD_WDATA;
          lanes_d = (WORD_MODE == 1) ? I_CMD_LANES : 2'h3;
          seq_d   = 3'h0;
          cnt_d   = '0;
          if (I_CMD == nvsac_pkg::CMD_HW_SAVE) begin
            hsb_d = 1'b1;
            st_d  = ST_HWREQ;
          end else if (I_CMD == nvsac_pkg::CMD_WRITE) begin
            cs_d = 1'b1;
            we_d = 1'b1;
            dqoe_d = 1'b1;
            st_d = ST_WRITE;
          end else begin
            if (I_CMD != nvsac_pkg::CMD_READ) begin
              addr_d = {1'b0, seq_addr(3'h0, I_CMD)};
            end
            if (I_CMD == nvsac_pkg::CMD_AUTO_OFF) begin
              nocap_d = 1'b1;
            end else if (I_CMD == nvsac_pkg::CMD_AUTO_ON) begin
              nocap_d = 1'b0;
            end
            cs_d = 1'b1;
            oe_d = 1'b1;
            st_d = ST_READ;
          end
        end
      end
      ST_READ: begin
        // Data follow the address, so wait the access time then sample.
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(nvsac_pkg::ADDR_ACCESS_CYC + 2)) begin
          rdata_d = dq_s;
          cs_d    = 1'b0;
          oe_d    = 1'b0;
          cnt_d   = '0;
          if (cmd_q == nvsac_pkg::CMD_READ || seq_q == 3'h5) begin
            rsp_d = (cmd_q == nvsac_pkg::CMD_READ);
            st_d  = (cmd_q == nvsac_pkg::CMD_READ) ? ST_RECOV : ST_BUSY;
          end else begin
            seq_d  = seq_q + 3'h1;
            st_d   = ST_RECOV;
          end
        end
      end
      ST_WRITE: begin
        // Address held; data captured at the rising write enable.
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(nvsac_pkg::WRITE_PULSE_CYC - 1)) begin
          we_d  = 1'b0;
          cs_d  = 1'b0;
          cnt_d = '0;
          st_d  = ST_RECOV;
        end
      end
      ST_RECOV: begin
        // One idle cycle lets the data bus turn around.
        dqoe_d = 1'b0;
        if (cmd_q == nvsac_pkg::CMD_READ || cmd_q == nvsac_pkg::CMD_WRITE) begin
          rsp_d = (cmd_q == nvsac_pkg::CMD_WRITE);
          st_d  = ST_IDLE;
        end else begin
          // The next sequence address moves only while select is high, so the
          // device never sees the address change as the previous read ends.
          addr_d = {1'b0, seq_addr(seq_q, cmd_q)};
          cs_d = 1'b1;
          oe_d = 1'b1;
          st_d = ST_READ;
        end
      end
      ST_HWREQ: begin
        hsb_d = 1'b1;
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(STORE_DELAY_CYC - 1)) begin
          hsb_d = 1'b0;
          cnt_d = '0;
          st_d  = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // Allow the device time to assert busy, then wait for it to clear.
        cnt_d = cnt_q + 1'b1;
        if ((cnt_q >= CW'(STORE_TIME_CYC)) || (cnt_q > CW'(4) && busy_n_s)) begin
          cnt_d = '0;
          st_d  = ST_WAITH;
        end
      end
      ST_WAITH: begin
        if (busy_n_s) begin
          rsp_d = 1'b1;
          st_d  = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_q <= ST_IDLE;  cnt_q <= '0;  seq_q <= 3'h0;  cmd_q <= 3'h0;
      addr_q <= '0;     wdata_q <= '0; rdata_q <= '0; lanes_q <= 2'h0;
      cs_q <= 1'b0;     oe_q <= 1'b0;  we_q <= 1'b0;  dqoe_q <= 1'b0;
      rsp_q <= 1'b0;    rdy_q <= 1'b0; hsb_q <= 1'b0; nocap_q <= 1'b0;
    end else begin
      st_q <= st_d;     cnt_q <= cnt_d; seq_q <= seq_d; cmd_q <= cmd_d;
      addr_q <= addr_d; wdata_q <= wdata_d; rdata_q <= rdata_d; lanes_q <= lanes_d;
      cs_q <= cs_d;     oe_q <= oe_d;   we_q <= we_d;   dqoe_q <= dqoe_d;
      rsp_q <= rsp_d;   rdy_q <= rdy_d; hsb_q <= hsb_d; nocap_q <= nocap_d;
    end
  end

  always_comb begin
    O_CMD_READY       = rdy_q;
    O_RSP_VALID       = rsp_q;
    O_RSP_RDATA       = rdata_q;
    O_NO_CAP_SEEN     = nocap_q;
    O_ADDR            = addr_q;
    O_CHIP_SELECT_N   = ~cs_q;
    O_OUTPUT_ENABLE_N = ~oe_q;
    O_WRITE_ENABLE_N  = ~we_q;
    // Byte enables follow the lanes alone, so a write keeps its lanes as select rises.
    O_UPPER_BYTE_EN_N = ~lanes_q[1];
    O_LOWER_BYTE_EN_N = ~lanes_q[0];
    O_DQ              = wdata_q;
    O_DQ_OE           = dqoe_q;
    O_STORE_BUSY_N    = 1'b0;
    O_STORE_BUSY_OE   = hsb_q;
  end

  a_write_oe_high: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    we_q |-> !oe_q) else $error("output enable low during write");
  a_read_no_we: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    oe_q |-> cs_q && !we_q) else $error("read without select");
  a_write_len: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    $rose(we_q) |-> we_q [*5] ##1 !we_q) else $error("write pulse length");
  a_addr_stable: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    we_q && $past(we_q) |-> $stable(addr_q)) else $error("address moved in write");
  a_hsb_no_access: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    hsb_q |-> !cs_q) else $error("access while requesting save");
  a_hwreq_len: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    $rose(hsb_q) |-> hsb_q [*2]) else $error("save request too short");
  a_ready_busy: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    rdy_q |-> $past(busy_n_s)) else $error("ready while busy low");
  a_nocap_seq: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    $rose(nocap_q) |-> ##[1:60] (addr_q[15:0] == nvsac_pkg::SEQ_AUTO_OFF))
    else $error("disable sequence missing");
  c_read: cover property (@(posedge I_SYS_CLK) rsp_q && cmd_q == nvsac_pkg::CMD_READ);
  c_write: cover property (@(posedge I_SYS_CLK) $fell(we_q));
  c_hwsave: cover property (@(posedge I_SYS_CLK) $fell(hsb_q));
  c_swsave: cover property (@(posedge I_SYS_CLK)
    st_q == ST_BUSY && cmd_q == nvsac_pkg::CMD_SW_SAVE);
endmodule : nvsac_host

/* src/nvsac_pkg.sv */
// Purpose: Constants for the host-side controller of a nonvolatile SRAM.
// Assumes: 100 MHz system clock, device timing given in ns.
// Notes:   Timing counts derive from the ns figures and the clock period.
package nvsac_pkg;
  localparam int unsigned CLK_PERIOD_NS       = 10;
  // Access and delay times in ns; plain defaults where no figure is given.
  localparam int unsigned ADDR_ACCESS_NS      = 45;
  localparam int unsigned WRITE_PULSE_NS      = 45;
  localparam int unsigned WRITE_OFF_DELAY_NS  = 15;
  localparam int unsigned STORE_REQ_DELAY_NS  = 25000;
  localparam int unsigned STORE_TIME_NS       = 8000000;
  localparam int unsigned ADDR_ACCESS_CYC     = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_CYC     = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
  localparam int unsigned WRITE_OFF_CYC       = (WRITE_OFF_DELAY_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
  localparam int unsigned STORE_REQ_DELAY_CYC = (STORE_REQ_DELAY_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
  localparam int unsigned STORE_TIME_CYC      = (STORE_TIME_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
  // Software sequence addresses.
  localparam logic [15:0] SEQ_ADDR_0          = 16'h4e38;
  localparam logic [15:0] SEQ_ADDR_1          = 16'hb1c7;
  localparam logic [15:0] SEQ_ADDR_2          = 16'h83e0;
  localparam logic [15:0] SEQ_ADDR_3          = 16'h7c1f;
  localparam logic [15:0] SEQ_ADDR_4          = 16'h703f;
  localparam logic [15:0] SEQ_SAVE            = 16'h8fc0;
  localparam logic [15:0] SEQ_AUTO_OFF        = 16'h8b45;
  localparam logic [15:0] SEQ_AUTO_ON         = 16'h4b46;
  localparam logic [15:0] SEQ_RESTORE         = 16'h4c63;
  localparam int unsigned BYTE_ADDR_W         = 17;
  localparam int unsigned WORD_ADDR_W         = 16;
  // Host commands.
  typedef enum logic [2:0] {
    CMD_READ      = 3'h0,
    CMD_WRITE     = 3'h1,
    CMD_SW_SAVE   = 3'h2,
    CMD_AUTO_OFF  = 3'h3,
    CMD_AUTO_ON   = 3'h4,
    CMD_RESTORE   = 3'h5,
    CMD_HW_SAVE   = 3'h6
  } nvsac_cmd_e;
endpackage : nvsac_pkg

/* src/nvsac_sync.sv */
// Purpose: Two flip-flop synchroniser for one pin level.
// Assumes: Input is asynchronous to the clock.
// Notes:   The first stage is read only by the second.
`timescale 1ns/1ns
module nvsac_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = i_d;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= RESET_VAL;
      o_q    <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      o_q    <= sync_d;
    end
  end
endmodule : nvsac_sync

/* test/nvsac_dev_model.sv */
// Purpose: Behavioural model of the nonvolatile SRAM seen from its pins.
// Assumes: Word-wide configuration; pins are already resolved by the bench.
// Notes:   Transfer times are shortened so that saves fit a short run.
`timescale 1ns/1ns
module nvsac_dev_model #(
  parameter int ACC_NS   = 45,
  parameter int DELAY_NS = 20,
  parameter int STORE_NS = 300
) (
  // Bus pins.
  input  wire logic [16:0] i_addr,
  input  wire logic        i_cs_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_ub_n,
  input  wire logic        i_lb_n,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq,
  output logic      [1:0]  o_dq_oe,
  // Save control.
  input  wire logic        i_busy_n,
  input  wire logic        i_power_fail,
  output logic             o_busy_drv
);
  logic [15:0] mem [65536];
  logic [15:0] nv  [65536];
  logic [15:0] unl [5];
  logic        pend     = 1'b0;
  logic        busy     = 1'b0;
  logic        auto_en  = 1'b1;
  int          seq_n    = 0;
  int          store_cnt = 0;
  wire rd = !i_cs_n && !i_oe_n && i_we_n && i_busy_n && !busy;
  wire wr = !i_cs_n && !i_we_n && i_busy_n && !busy;
  initial begin
    o_busy_drv = 1'b0;
    unl = '{nvsac_pkg::SEQ_ADDR_0, nvsac_pkg::SEQ_ADDR_1, nvsac_pkg::SEQ_ADDR_2,
            nvsac_pkg::SEQ_ADDR_3, nvsac_pkg::SEQ_ADDR_4};
  end
  assign #(ACC_NS) o_dq = mem[i_addr[15:0]];
  // Drivers drop at once when write enable falls, well inside the allowed delay.
  assign o_dq_oe = {2{rd}} & ~{i_ub_n, i_lb_n};
  task automatic xfer(input bit restore);
    busy       = 1'b1;
    o_busy_drv = 1'b1;
    #(STORE_NS);
    if (restore) begin
      mem = nv;
    end else begin
      nv        = mem;
      store_cnt = store_cnt + 1;
    end
    pend       = 1'b0;
    busy       = 1'b0;
    o_busy_drv = 1'b0;
  endtask : xfer
  always @(negedge wr) begin
    if (i_cs_n || i_we_n) begin
      if (!i_lb_n) mem[i_addr[15:0]][7:0] = i_dq[7:0];
      if (!i_ub_n) mem[i_addr[15:0]][15:8] = i_dq[15:8];
      pend  = 1'b1;
      seq_n = 0;
    end
  end
  always @(negedge rd) begin
    if (seq_n == 5) begin
      seq_n = 0;
      case (i_addr[15:0])
        nvsac_pkg::SEQ_SAVE:     xfer(1'b0);
        nvsac_pkg::SEQ_RESTORE:  xfer(1'b1);
        nvsac_pkg::SEQ_AUTO_OFF: auto_en = 1'b0;
        nvsac_pkg::SEQ_AUTO_ON:  auto_en = 1'b1;
        default:                 seq_n = 0;
      endcase
    end else if (i_addr[15:0] == unl[seq_n]) begin
      seq_n = seq_n + 1;
    end else begin
      seq_n = (i_addr[15:0] == unl[0]) ? 1 : 0;
    end
  end
  always @(negedge i_busy_n) begin
    if (!busy) begin
      #(DELAY_NS);
      if (pend) xfer(1'b0);
    end
  end
  always @(posedge i_power_fail) begin
    if (auto_en && pend && !busy) xfer(1'b0);
  end
endmodule : nvsac_dev_model

/* test/tb_nvsac_host.sv */
// Purpose: Self-checking bench for the host controller against a device model.
// Assumes: Word-wide configuration with shortened save delays.
// Notes:   Data lines nobody drives toggle every cycle to expose stale reads.
`timescale 1ns/1ns
module tb_nvsac_host;
  logic clk = 1'b0, arst_n = 1'b0, vld = 1'b0, pfail = 1'b0;
  logic [2:0]  cmd = 3'h0;
  logic [16:0] addr = 17'h0;
  logic [15:0] wd = 16'h0, fl = 16'h0, got, d, ka;
  logic [1:0]  ln = 2'h0, l;
  logic [15:0] sh [logic [15:0]];
  logic [15:0] keys [16];
  int error_cnt = 0, tests_run = 0, n0;
  wire rdy, rv, nocap, cs_n, oe_n, we_n, ub_n, lb_n, dq_oe, bsy_o, bsy_oe, drv, busy_n;
  wire [16:0] pa;
  wire [15:0] rdat, hdq, ddq, dq;
  wire [1:0]  doe;
  assign dq[15:8] = dq_oe ? hdq[15:8] : doe[1] ? ddq[15:8] : fl[15:8];
  assign dq[7:0]  = dq_oe ? hdq[7:0] : doe[0] ? ddq[7:0] : fl[7:0];
  assign busy_n   = ((bsy_oe && !bsy_o) || drv) ? 1'b0 : 1'b1;
  always #5 clk = ~clk;
  always @(posedge clk) fl <= ~fl;
  nvsac_host #(.STORE_DELAY_CYC(4), .STORE_TIME_CYC(50)) dut (
    .I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_CMD_VALID(vld), .I_CMD(cmd),
    .I_CMD_ADDR(addr), .I_CMD_WDATA(wd), .I_CMD_LANES(ln), .O_CMD_READY(rdy),
    .O_RSP_VALID(rv), .O_RSP_RDATA(rdat), .O_NO_CAP_SEEN(nocap), .O_ADDR(pa),
    .O_CHIP_SELECT_N(cs_n), .O_OUTPUT_ENABLE_N(oe_n), .O_WRITE_ENABLE_N(we_n),
    .O_UPPER_BYTE_EN_N(ub_n), .O_LOWER_BYTE_EN_N(lb_n), .I_DQ(dq), .O_DQ(hdq),
    .O_DQ_OE(dq_oe), .I_STORE_BUSY_N(busy_n), .O_STORE_BUSY_N(bsy_o),
    .O_STORE_BUSY_OE(bsy_oe));
  nvsac_dev_model m (
    .i_addr(pa), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_ub_n(ub_n),
    .i_lb_n(lb_n), .i_dq(dq), .o_dq(ddq), .o_dq_oe(doe), .i_busy_n(busy_n),
    .i_power_fail(pfail), .o_busy_drv(drv));
  function automatic logic [15:0] msk(input logic [1:0] lanes);
    return {{8{lanes[1]}}, {8{lanes[0]}}};
  endfunction : msk
  function automatic logic [15:0] mrg(input logic [15:0] o, input logic [15:0] v,
                                      input logic [1:0] lanes);
    return (o & ~msk(lanes)) | (v & msk(lanes));
  endfunction : mrg
  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick_or_quit(inout int k);
    @(posedge clk);
    k++;
    if (k > 3000) begin
      error_cnt++;
      close_out();
    end
  endtask : tick_or_quit
  // Called just after a rising edge; the request holds until it is taken.
  task automatic op(input logic [2:0] c, input logic [15:0] a, input logic [15:0] v,
                    input logic [1:0] lanes);
    int k;
    k = 0;
    cmd  <= c;
    addr <= {1'b0, a};
    wd   <= v;
    ln   <= lanes;
    vld  <= 1'b1;
    do tick_or_quit(k); while (rdy !== 1'b1);
    vld <= 1'b0;
    do tick_or_quit(k); while (rv !== 1'b1);
    got = rdat;
  endtask : op
  task automatic power_loss();
    int k;
    k = 0;
    pfail <= 1'b1;
    repeat (4) @(posedge clk);
    pfail <= 1'b0;
    while (busy_n !== 1'b1) tick_or_quit(k);
  endtask : power_loss
  initial begin
    void'($urandom(32'h721c));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      keys[i] = 16'($urandom);
      d       = 16'($urandom);
      op(nvsac_pkg::CMD_WRITE, keys[i], d, 2'h3);
      sh[keys[i]] = d;
    end
    for (int i = 0; i < 48; i++) begin
      ka = keys[$urandom_range(15)];
      l  = 2'($urandom_range(3, 1));
      d  = 16'($urandom);
      if ($urandom_range(1) == 1) begin
        op(nvsac_pkg::CMD_WRITE, ka, d, l);
        sh[ka] = mrg(sh[ka], d, l);
      end else begin
        op(nvsac_pkg::CMD_READ, ka, 16'h0, l);
        chk(got & msk(l), sh[ka] & msk(l));
      end
    end
    op(nvsac_pkg::CMD_WRITE, keys[0], 16'h5a5a, 2'h3);
    n0 = m.store_cnt;
    op(nvsac_pkg::CMD_HW_SAVE, 16'h0, 16'h0, 2'h3);
    chk(16'(m.store_cnt), 16'(n0 + 1));
    op(nvsac_pkg::CMD_WRITE, keys[0], 16'ha5a5, 2'h3);
    op(nvsac_pkg::CMD_RESTORE, 16'h0, 16'h0, 2'h3);
    op(nvsac_pkg::CMD_READ, keys[0], 16'h0, 2'h3);
    chk(got, 16'h5a5a);
    op(nvsac_pkg::CMD_HW_SAVE, 16'h0, 16'h0, 2'h3);
    chk(16'(m.store_cnt), 16'(n0 + 1));
    op(nvsac_pkg::CMD_SW_SAVE, 16'h0, 16'h0, 2'h3);
    chk(16'(m.store_cnt), 16'(n0 + 2));
    op(nvsac_pkg::CMD_AUTO_OFF, 16'h0, 16'h0, 2'h3);
    chk({15'h0, nocap}, 16'h1);
    chk({15'h0, m.auto_en}, 16'h0);
    op(nvsac_pkg::CMD_WRITE, keys[1], 16'h1234, 2'h3);
    power_loss();
    chk(16'(m.store_cnt), 16'(n0 + 2));
    op(nvsac_pkg::CMD_AUTO_ON, 16'h0, 16'h0, 2'h3);
    chk({15'h0, nocap}, 16'h0);
    power_loss();
    chk(16'(m.store_cnt), 16'(n0 + 3));
    op(nvsac_pkg::CMD_READ, keys[1], 16'h0, 2'h1);
    chk(got & 16'h00ff, 16'h0034);
    close_out();
  end
endmodule : tb_nvsac_host
